// [rtl/hbd_decoder.sv]
`timescale 1ns/1ps
module hbd_decoder #(
    parameter int NPH       = hbd_pkg::NPH,
    parameter int READY_CYC = hbd_pkg::READY_CYC,
    parameter int DEAD_CYC  = hbd_pkg::DEAD_CYC,
    parameter int GDF_CYC   = hbd_pkg::GDF_CYC
) (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             srst_i,
    // enable and supply
    input  wire logic             enable_i,
    input  wire logic             supply_ok_i,
    // configuration source
    input  wire logic             serial_variant_i,
    input  wire logic [1:0]       mode_field_i,
    input  wire logic [1:0]       mode_strap_i,
    // commands per phase
    input  wire logic [NPH-1:0]   high_side_command_in_i,
    input  wire logic [NPH-1:0]   low_side_command_in_i,
    // gate feedback and fault
    input  wire logic [NPH-1:0]   gate_ok_i,
    input  wire logic             ext_fault_i,
    input  wire logic             fault_clr_i,
    // gate drive
    output logic [NPH-1:0]        high_gate_drive_out_o,
    output logic [NPH-1:0]        low_gate_drive_out_o,
    // hand-over for other modes
    output logic                  other_mode_o,
    output logic [1:0]            active_mode_o,
    // status
    output logic                  fault_indicator_n_o,
    output logic [NPH+1:0]        fault_detail_o,
    output logic                  serial_ready_o
);
    function automatic logic [1:0] strap_to_mode(input logic [1:0] s);
        case (s)
            hbd_pkg::STRAP_GND: strap_to_mode = hbd_pkg::MODE_6X;
            hbd_pkg::STRAP_RES: strap_to_mode = hbd_pkg::MODE_3X;
            hbd_pkg::STRAP_HIZ: strap_to_mode = hbd_pkg::MODE_1X;
            default:            strap_to_mode = hbd_pkg::MODE_IND;
        endcase
    endfunction : strap_to_mode

    logic [1:0]     mode_ff;
    logic           mode_mine_ff;
    logic [23:0]    rdy_cnt_ff;
    logic           rdy_ff;
    logic [NPH-1:0] gdf;
    logic           ext_ff;
    logic           flt_n_ff;
    logic [NPH+1:0] detail_ff;

    // mode select from field or strap
    wire logic [1:0] sel_mode = serial_variant_i ? mode_field_i
                                                 : strap_to_mode(mode_strap_i);
    wire logic       active   = enable_i && supply_ok_i;

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            mode_ff      <= hbd_pkg::MODE_6X;
            mode_mine_ff <= 1'b1;
        end
        else
        begin
            mode_ff      <= sel_mode;
            mode_mine_ff <= (sel_mode == hbd_pkg::MODE_6X)
                            || (sel_mode == hbd_pkg::MODE_3X);
        end
    end

    // serial ready timer
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i || !active)
        begin
            rdy_cnt_ff <= 24'h000000;
            rdy_ff     <= 1'b0;
        end
        else if (!rdy_ff)
        begin
            rdy_cnt_ff <= rdy_cnt_ff + 24'h000001;
            rdy_ff     <= (rdy_cnt_ff + 24'h000001 >= 24'(READY_CYC));
        end
    end

    genvar p;
    generate
        for (p = 0; p < NPH; p++)
        begin : g_ph
            wire logic hin = high_side_command_in_i[p];
            wire logic lin = low_side_command_in_i[p];
            // six-input map: both-high floats
            wire logic rh6 = hin && !lin;
            wire logic rl6 = lin && !hin;
            // three-input map: low command enables
            wire logic rh3 = lin && hin;
            wire logic rl3 = lin && !hin;
            wire logic is3 = (mode_ff == hbd_pkg::MODE_3X);
            wire logic go  = active && mode_mine_ff;
            wire logic rh  = go && (is3 ? rh3 : rh6);
            wire logic rl  = go && (is3 ? rl3 : rl6);

            hbd_phase #(
                .DEAD_CYC (DEAD_CYC),
                .GDF_CYC  (GDF_CYC)
            ) u_phase (
                .sys_clk_i             (sys_clk_i),
                .srst_i                (srst_i),
                .req_high_i            (rh),
                .req_low_i             (rl),
                .gate_ok_i             (gate_ok_i[p]),
                .fault_clr_i           (fault_clr_i),
                .high_gate_drive_out_o (high_gate_drive_out_o[p]),
                .low_gate_drive_out_o  (low_gate_drive_out_o[p]),
                .gdf_o                 (gdf[p])
            );
        end
    endgenerate

    // fault reporting, set wins over clear
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            ext_ff    <= 1'b0;
            flt_n_ff  <= 1'b1;
            detail_ff <= '0;
        end
        else
        begin
            ext_ff    <= ext_fault_i || (ext_ff && !fault_clr_i);
            flt_n_ff  <= !((|gdf) || ext_fault_i || (ext_ff && !fault_clr_i));
            detail_ff <= {ext_fault_i || (ext_ff && !fault_clr_i), gdf, 1'b0};
        end
    end

    assign fault_indicator_n_o = flt_n_ff;
    assign fault_detail_o      = detail_ff;
    assign serial_ready_o      = rdy_ff;
    assign other_mode_o        = !mode_mine_ff;
    assign active_mode_o       = mode_ff;
endmodule : hbd_decoder

// [rtl/hbd_pkg.sv]
// Overview of operation
// - four bridge input modes, chosen by a two-bit field or a decoded strap level.
// - mode 00b (or strap to analog ground) gives each phase low, high or floating.
// - six-input mode: 00 and 11 float the phase, high-only drives high, low-only drives low.
// - mode 01b (or resistor strap) lets the high command pick phase low or high when the low command enables.
// - three-input mode: low command at 0 turns both gates off so the phase floats.
// - three-input mode with low command at 1: high command 0 turns on low gate, 1 the high.
// - the serial port is ready within 1 ms of enable with supply good; no transfer before.
// - a state machine inserts dead time and detects gate faults.
// - the high gate may stay on without limit, so 100% duty is allowed.
// - faults show on the active-low fault output and in readable fault detail bits.
// - configuration comes from the serial field or from the straps on the hardware variant.
// - modes 10b and 11b hand gate control to the other decoders outside this block.
package hbd_pkg;
    localparam int          CLK_HZ         = 10_000_000;
    localparam int          READY_MS       = 1;
    localparam int          READY_CYC      = CLK_HZ / 1000 * READY_MS;
    localparam int          DEAD_NS        = 100;
    localparam int          DEAD_CYC       = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int          GDF_NS         = 1000;
    localparam int          GDF_CYC        = GDF_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam int          NPH            = 3;
    localparam logic [1:0]  MODE_6X        = 2'h0;
    localparam logic [1:0]  MODE_3X        = 2'h1;
    localparam logic [1:0]  MODE_1X        = 2'h2;
    localparam logic [1:0]  MODE_IND       = 2'h3;
    localparam logic [1:0]  STRAP_GND      = 2'h0;
    localparam logic [1:0]  STRAP_RES      = 2'h1;
    localparam logic [1:0]  STRAP_HIZ      = 2'h2;
    localparam logic [1:0]  STRAP_HIGH     = 2'h3;
    localparam int          FLT_GDF_POS    = 0;
    localparam int          FLT_EXT_POS    = 1;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_DEAD,
        ST_LOW_ON,
        ST_HIGH_ON,
        ST_FAULT
    } hbd_state_t;
endpackage : hbd_pkg

// [rtl/hbd_phase.sv]
`timescale 1ns/1ps
module hbd_phase #(
    parameter int DEAD_CYC = hbd_pkg::DEAD_CYC,
    parameter int GDF_CYC  = hbd_pkg::GDF_CYC
) (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic srst_i,
    // decoded request
    input  wire logic req_high_i,
    input  wire logic req_low_i,
    input  wire logic gate_ok_i,
    input  wire logic fault_clr_i,
    // gate drive
    output logic      high_gate_drive_out_o,
    output logic      low_gate_drive_out_o,
    output logic      gdf_o
);
    hbd_pkg::hbd_state_t state_ff;
    hbd_pkg::hbd_state_t nxt_state;
    logic [7:0]          cnt_ff;
    logic [7:0]          nxt_cnt;
    logic                hi_ff;
    logic                lo_ff;

    wire logic on_state = (state_ff == hbd_pkg::ST_HIGH_ON) || (state_ff == hbd_pkg::ST_LOW_ON);
    wire logic want_same = (state_ff == hbd_pkg::ST_HIGH_ON) ? (req_high_i && !req_low_i)
                                                              : (req_low_i && !req_high_i);
    wire logic gdf_hit  = on_state && want_same && !gate_ok_i
                          && (cnt_ff >= 8'(GDF_CYC));

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            hbd_pkg::ST_OFF:
            begin
                nxt_cnt = 8'h00;
                if (req_high_i ^ req_low_i)
                    nxt_state = hbd_pkg::ST_DEAD;
            end
            hbd_pkg::ST_DEAD:
            begin
                nxt_cnt = cnt_ff + 8'h01;
                if (!(req_high_i ^ req_low_i))
                    nxt_state = hbd_pkg::ST_OFF;
                else if (cnt_ff + 8'h01 >= 8'(DEAD_CYC))
                begin
                    nxt_state = req_high_i ? hbd_pkg::ST_HIGH_ON : hbd_pkg::ST_LOW_ON;
                    nxt_cnt   = 8'h00;
                end
            end
            hbd_pkg::ST_HIGH_ON,
            hbd_pkg::ST_LOW_ON:
            begin
                if (cnt_ff != 8'hFF)
                    nxt_cnt = cnt_ff + 8'h01;
                if (gdf_hit)
                    nxt_state = hbd_pkg::ST_FAULT;
                else if (!want_same)
                begin
                    nxt_state = hbd_pkg::ST_DEAD;
                    nxt_cnt   = 8'h00;
                end
            end
            hbd_pkg::ST_FAULT:
            begin
                nxt_cnt = 8'h00;
                if (fault_clr_i && !req_high_i && !req_low_i)
                    nxt_state = hbd_pkg::ST_OFF;
            end
            default:
            begin
                nxt_state = hbd_pkg::ST_OFF;
                nxt_cnt   = 8'h00;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            state_ff <= hbd_pkg::ST_OFF;
            cnt_ff   <= 8'h00;
            hi_ff    <= 1'b0;
            lo_ff    <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            hi_ff    <= (nxt_state == hbd_pkg::ST_HIGH_ON);
            lo_ff    <= (nxt_state == hbd_pkg::ST_LOW_ON);
        end
    end

    assign high_gate_drive_out_o = hi_ff;
    assign low_gate_drive_out_o  = lo_ff;
    assign gdf_o                 = (state_ff == hbd_pkg::ST_FAULT);
endmodule : hbd_phase

// [sim/hbd_checker_assertions.sv]
`timescale 1ns/1ps
module hbd_checker #(
    parameter int NPH       = 3,
    parameter int READY_CYC = 20
) (
    // clock, reset and inputs
    input wire logic           sys_clk_i,
    input wire logic           srst_i,
    input wire logic           enable_i,
    input wire logic           supply_ok_i,
    input wire logic [NPH-1:0] high_side_command_in_i,
    input wire logic [NPH-1:0] low_side_command_in_i,
    input wire logic [NPH-1:0] gate_ok_i,
    // outputs
    input wire logic [NPH-1:0] high_gate_drive_out_o,
    input wire logic [NPH-1:0] low_gate_drive_out_o,
    input wire logic           other_mode_o,
    input wire logic [1:0]     active_mode_o,
    input wire logic           fault_indicator_n_o,
    input wire logic [NPH+1:0] fault_detail_o,
    input wire logic           serial_ready_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    int unsigned         up_ff;
    wire logic           pwr_ok = enable_i && supply_ok_i;
    wire logic [NPH-1:0] hg     = high_gate_drive_out_o;
    wire logic [NPH-1:0] lg     = low_gate_drive_out_o;
    wire logic           clean  = pwr_ok && fault_indicator_n_o && fault_detail_o == '0;
    // cycles since enable with good supply
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i || !pwr_ok)
            up_ff <= 0;
        else if (up_ff < READY_CYC + 8)
            up_ff <= up_ff + 1;
    end
    a_no_shoot:
    assert property ((hg & lg) == '0) else $error("both gates of a phase on");
    a_dead_gap:
    assert property (((hg & $past(lg)) | (lg & $past(hg))) == '0) else $error("no dead gap");
    a_six_high:
    assert property ((clean && gate_ok_i[0] && active_mode_o == 2'h0 && !other_mode_o
        && high_side_command_in_i[0] && !low_side_command_in_i[0])[*5]
        |-> hg[0] && !lg[0]) else $error("six-input high not driven");
    a_three_float:
    assert property ((active_mode_o == 2'h1 && !low_side_command_in_i[0])[*3]
        |-> !hg[0] && !lg[0]) else $error("three-input phase not floating");
    a_other_off:
    assert property (other_mode_o |-> (hg | lg) == '0) else $error("gates on in other mode");
    a_fault_flag:
    assert property ($rose(|fault_detail_o) |-> ##[0:1] !fault_indicator_n_o)
        else $error("fault not signalled");
    a_ready_early:
    assert property (serial_ready_o |-> up_ff + 3 >= READY_CYC) else $error("ready too early");
    a_ready_late:
    assert property (up_ff >= READY_CYC + 3 |-> serial_ready_o) else $error("ready too late");
endmodule : hbd_checker

bind hbd_decoder hbd_checker #(.NPH(NPH), .READY_CYC(READY_CYC)) i_hbd_checker (
    .sys_clk_i, .srst_i, .enable_i, .supply_ok_i, .high_side_command_in_i,
    .low_side_command_in_i, .gate_ok_i, .high_gate_drive_out_o, .low_gate_drive_out_o,
    .other_mode_o, .active_mode_o, .fault_indicator_n_o, .fault_detail_o, .serial_ready_o);

// [sim/hbd_ctrl_model.sv]
`timescale 1ns/1ps
module hbd_ctrl_model (
    // requests from the bench
    input  wire logic       quiet_i,
    input  wire logic       gate_bad_i,
    input  wire logic [2:0] want_h_i,
    input  wire logic [2:0] want_l_i,
    // pins toward the decoder
    output logic [2:0]      high_side_command_in_o,
    output logic [2:0]      low_side_command_in_o,
    output logic [2:0]      gate_ok_o
);
    assign high_side_command_in_o = quiet_i ? 3'h0 : want_h_i;
    assign low_side_command_in_o  = quiet_i ? 3'h0 : want_l_i;
    assign gate_ok_o              = {2'h3, !gate_bad_i};
endmodule : hbd_ctrl_model

// [sim/hbd_decoder_test.sv]
`timescale 1ns/1ps
module hbd_decoder_test;
    logic       clk, srst, en, sup, sv, bad, ef, fc, quiet, other, flt_n, rdy;
    logic [1:0] mf, ms, amode;
    logic [2:0] want_h, want_l, hc, lc, gok, hg, lg;
    logic [4:0] fd;
    int         err_total, check_count, md;

    initial
    begin
        clk = 0;
        forever #50 clk = ~clk;
    end

    hbd_decoder #(.READY_CYC(20)) i_hbd_decoder (.sys_clk_i(clk), .srst_i(srst),
        .enable_i(en), .supply_ok_i(sup), .serial_variant_i(sv), .mode_field_i(mf),
        .mode_strap_i(ms), .high_side_command_in_i(hc), .low_side_command_in_i(lc),
        .gate_ok_i(gok), .ext_fault_i(ef), .fault_clr_i(fc), .high_gate_drive_out_o(hg),
        .low_gate_drive_out_o(lg), .other_mode_o(other), .active_mode_o(amode),
        .fault_indicator_n_o(flt_n), .fault_detail_o(fd), .serial_ready_o(rdy));
    hbd_ctrl_model i_hbd_ctrl_model (.quiet_i(quiet), .gate_bad_i(bad), .want_h_i(want_h),
        .want_l_i(want_l), .high_side_command_in_o(hc), .low_side_command_in_o(lc),
        .gate_ok_o(gok));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [5:0] model_gates(int h, int l);
        int hi;
        int lo;
        hi = 0;
        lo = 0;
        for (int p = 0; p < 3; p++)
        begin
            if (md == 0 && h[p] != l[p])
            begin
                hi |= h & (1 << p);
                lo |= l & (1 << p);
            end
            if (md == 1 && l[p])
            begin
                hi |= h & (1 << p);
                lo |= ~h & (1 << p);
            end
        end
        return {hi[2:0], lo[2:0]};
    endfunction : model_gates

    task automatic apply(input int h, input int l);
        want_h = h[2:0];
        want_l = l[2:0];
        repeat (8) @(negedge clk);
        check("gates", {2'h0, hg, lg}, {2'h0, model_gates(h, l)});
    endtask : apply

    task automatic set_mode(input int m);
        quiet = 1;
        repeat (3) @(negedge clk);
        mf = m[1:0];
        ms = m[1:0];
        md = m;
        repeat (3) @(negedge clk);
        check("mode", {6'h0, amode}, m[7:0]);
        check("other", {7'h0, other}, {7'h0, m > 1});
        quiet = 0;
    endtask : set_mode

    task automatic clear_faults();
        want_h = 3'h0;
        want_l = 3'h0;
        bad = 0;
        repeat (4) @(negedge clk);
        fc = 1;
        @(negedge clk);
        fc = 0;
        repeat (3) @(negedge clk);
        check("cleared", {2'h0, flt_n, fd}, 8'h20);
    endtask : clear_faults

    task automatic results();
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    initial
    begin
        {srst, en, sup, sv, bad, ef, fc, quiet} = 8'h80;
        {mf, ms, want_h, want_l} = 10'h000;
        md = 0;
        err_total = 0;
        check_count = 0;
        void'($urandom(1));
        repeat (5) @(negedge clk);
        srst = 0;
        check("reset", {flt_n, rdy, hg, lg}, 8'h80);
        en = 1;
        sup = 1;
        repeat (10) @(negedge clk);
        check("early", {7'h0, rdy}, 8'h00);
        repeat (15) @(negedge clk);
        check("ready", {7'h0, rdy}, 8'h01);
        sv = 1;
        for (int m = 0; m < 2; m++)
        begin
            set_mode(m);
            repeat (30) apply($urandom % 8, $urandom % 8);
        end
        apply(7, 7);
        repeat (200) @(negedge clk);
        check("full duty", {5'h0, hg}, 8'h07);
        bad = 1;
        repeat (20) @(negedge clk);
        check("gate fault", {1'h0, flt_n, fd, hg[0]}, 8'h04);
        clear_faults();
        ef = 1;
        @(negedge clk);
        ef = 0;
        repeat (3) @(negedge clk);
        check("ext fault", {2'h0, flt_n, fd}, 8'h10);
        clear_faults();
        sv = 0;
        for (int m = 0; m < 4; m++)
        begin
            set_mode(m);
            apply(7, 3);
        end
        en = 0;
        repeat (3) @(negedge clk);
        check("disabled", {1'h0, rdy, hg, lg}, 8'h00);
        results();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        results();
    end
endmodule : hbd_decoder_test
